// ==== shared/cprm_pkg.sv ====
// constants for the core programmer register model
// assumes one core clock and a plain register port from the execution logic
// Behaviour
// - instruction words are 24 bits wide
// - program counter 23 bits, bit 0 zero
// - program counter top bit ignored normally
// - sixteen 16-bit working registers, memory mapped
// - stack pointer auto-updated, still ordinary register
// - stack pointer bit 0 always zero
// - stack pointer resets to 0x0800
// - frame pointer for link/unlink, also general
// - data space split X/Y, dual generators
// - upper data reads map via visibility page
// - table access reaches all 24 bits
// - byte op changes low byte only
// - shadow push/pop first four registers, flags
// - loop entry saves, exit restores loop registers
// - shadows not directly software accessible
// - status low: flags, priority level, repeat
// - exception stacks status low with pc high
// - status high: dsp flags, loop, digit carry
// - 62 vectors: 8 traps, 54 interrupts
// - interrupt priority 1..7, traps 8..15
// - shift right 15 or left 16
// - single prefetch stage, loops interruptible
package cprm_pkg;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [22:0] PC_RESET = 23'h000000;
  localparam logic [15:0] SR_RESET = 16'h0000;
  // register map (word offsets into the sfr area, byte addresses)
  localparam logic [15:0] OFS_SPLIM = 16'h0020;
  localparam logic [15:0] OFS_PCL = 16'h002e;
  localparam logic [15:0] OFS_PCH = 16'h0030;
  localparam logic [15:0] OFS_TBLPG = 16'h0032;
  localparam logic [15:0] OFS_PSVPG = 16'h0034;
  localparam logic [15:0] OFS_RPTCNT = 16'h0036;
  localparam logic [15:0] OFS_LPCNT = 16'h0038;
  localparam logic [15:0] OFS_LPSTL = 16'h003a;
  localparam logic [15:0] OFS_LPSTH = 16'h003c;
  localparam logic [15:0] OFS_LPENL = 16'h003e;
  localparam logic [15:0] OFS_LPENH = 16'h0040;
  localparam logic [15:0] OFS_STATUS = 16'h0042;
  // status bit positions
  localparam int SR_RA = 4;
  localparam int SR_IPL_LO = 5;
  localparam int SR_DA = 9;
  // flags kept by the shadow push: dc, n, ov, z, c
  localparam logic [15:0] SR_SHADOW_MASK = 16'h010f;
  // hardware-owned status bits software writes cannot touch (ra, da)
  localparam logic [15:0] SR_HW_MASK = 16'h0210;
  // program visibility window
  localparam logic [15:0] PSV_BASE = 16'h8000;
  // exceptions
  localparam int NUM_TRAP = 8;
  localparam int NUM_IRQ = 54;
  localparam logic [3:0] TRAP_PRI_BASE = 4'h8;
  localparam logic [2:0] IRQ_PRI_MIN = 3'h1;
  typedef enum logic [1:0] {CPRM_EXC_IDLE, CPRM_EXC_PUSH_PC, CPRM_EXC_PUSH_SR} cprm_exc_t;
endpackage : cprm_pkg

// ==== hw/cprm_core_regs.sv ====
// programmer-visible register model of the core
// assumes the execution logic drives the event strobes; memories sit outside
`timescale 1ns/100ps
module cprm_core_regs #(
  parameter int NUM_IRQ = cprm_pkg::NUM_IRQ,
  parameter int NUM_TRAP = cprm_pkg::NUM_TRAP
) (
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [1:0] reg_wbyte,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // working register file port from execution
  input wire logic [3:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic wr_byte,
  input wire logic [3:0] rd_sel_a,
  input wire logic [3:0] rd_sel_b,
  output logic [15:0] rd_data_a,
  output logic [15:0] rd_data_b,
  // flag update from alu
  input wire logic [15:0] flag_data,
  input wire logic [15:0] flag_mask,
  input wire logic flag_en,
  // program counter control
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [22:0] pc_target,
  input wire logic pc_special,
  output logic [22:0] pc_value,
  output logic [22:0] fetch_addr,
  input wire logic [23:0] fetch_word,
  output logic [23:0] instr_word,
  // stack events
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic [15:0] stack_rdata,
  output logic [15:0] stack_addr,
  output logic [15:0] stack_wdata,
  output logic stack_we,
  // frame link / unlink
  input wire logic frame_link,
  input wire logic frame_unlink,
  input wire logic [13:0] frame_size,
  // shadow and loop events
  input wire logic shadow_push,
  input wire logic shadow_pop,
  input wire logic loop_enter,
  input wire logic loop_exit,
  input wire logic [22:0] loop_start_in,
  input wire logic [22:0] loop_end_in,
  input wire logic [13:0] loop_count_in,
  input wire logic repeat_start,
  input wire logic repeat_done,
  input wire logic [13:0] repeat_count_in,
  // data address generation
  input wire logic [15:0] x_ea,
  input wire logic [15:0] y_ea,
  input wire logic dual_op,
  output logic x_en,
  output logic y_en,
  output logic psv_access,
  output logic [22:0] psv_addr,
  output logic psv_wait,
  input wire logic [15:0] tbl_offset,
  output logic [22:0] tbl_addr,
  // exceptions
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [3*NUM_IRQ-1:0] irq_pri,
  input wire logic [NUM_TRAP-1:0] trap_req,
  input wire logic exc_ack,
  output logic exc_pending,
  output logic [5:0] exc_vector,
  // shifter
  input wire logic [39:0] shift_in,
  input wire logic signed [5:0] shift_amt,
  output logic [39:0] shift_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] wreg [0:15];
  logic [15:0] wshadow [0:3];
  logic [15:0] status_reg;
  logic [15:0] sr_shadow;
  logic [22:0] pc_reg;
  logic [23:0] instr_reg;
  logic [7:0] table_page_reg;
  logic [7:0] program_visibility_page;
  logic [13:0] repeat_counter;
  logic [13:0] loop_counter;
  logic [22:0] loop_start_address;
  logic [22:0] loop_end_address;
  logic [13:0] lc_shadow;
  logic [22:0] ls_shadow;
  logic [22:0] le_shadow;
  logic shadow_valid;
  logic psv_wait_reg;
  cprm_pkg::cprm_exc_t exc_state;
  logic [15:0] sp;
  logic [15:0] sp_next;
  logic [15:0] exc_word;
  logic [5:0] vec_next;
  logic pend_next;
  logic [3:0] best_pri;
  logic map_hit;
  logic [3:0] map_idx;

  assign sp = {wreg[15][15:1], 1'b0};
  assign map_hit = (reg_addr < cprm_pkg::OFS_SPLIM);
  assign map_idx = reg_addr[4:1];

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer motion
  always_comb begin
    sp_next = sp;
    if (exc_state == cprm_pkg::CPRM_EXC_PUSH_PC || exc_state == cprm_pkg::CPRM_EXC_PUSH_SR ||
        call_push) begin
      sp_next = sp + 16'h0002;
    end else if (ret_pop) begin
      sp_next = sp - 16'h0002;
    end
    if (frame_link) begin
      sp_next = sp + 16'h0002 + {1'b0, frame_size, 1'b0};
    end else if (frame_unlink) begin
      sp_next = wreg[14] - 16'h0002;
    end
  end

  assign exc_word = {pc_reg[22:16], 1'b0, status_reg[7:0]};

  always_comb begin
    stack_we = 1'b0;
    stack_addr = sp;
    stack_wdata = 16'h0000;
    case (exc_state)
      cprm_pkg::CPRM_EXC_PUSH_PC: begin
        stack_we = 1'b1;
        stack_wdata = pc_reg[15:0];
      end
      cprm_pkg::CPRM_EXC_PUSH_SR: begin
        stack_we = 1'b1;
        stack_wdata = exc_word;
      end
      default: begin
        if (call_push) begin
          stack_we = 1'b1;
          stack_wdata = pc_reg[15:0];
        end else if (frame_link) begin
          stack_we = 1'b1;
          stack_wdata = wreg[14];
        end else if (ret_pop) begin
          stack_addr = sp - 16'h0002;
        end else if (frame_unlink) begin
          stack_addr = wreg[14] - 16'h0002;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // working registers
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 15; i++) begin
        wreg[i] <= 16'h0000;
      end
      wreg[15] <= cprm_pkg::SP_RESET;
    end else begin
      if (wr_en) begin
        if (wr_byte) begin
          wreg[wr_sel][7:0] <= wr_data[7:0];
        end else begin
          wreg[wr_sel] <= wr_data;
        end
      end
      if (reg_write && map_hit) begin
        if (reg_wbyte[0]) begin
          wreg[map_idx][7:0] <= reg_wdata[7:0];
        end
        if (reg_wbyte[1]) begin
          wreg[map_idx][15:8] <= reg_wdata[15:8];
        end
      end
      if (shadow_pop && shadow_valid) begin
        for (int i = 0; i < 4; i++) begin
          wreg[i] <= wshadow[i];
        end
      end
      if (frame_link) begin
        wreg[14] <= sp + 16'h0002;
      end else if (frame_unlink) begin
        wreg[14] <= stack_rdata;
      end
      if (sp_next != sp) begin
        wreg[15] <= sp_next;
      end
      wreg[15][0] <= 1'b0;
    end
  end

  assign rd_data_a = (rd_sel_a == 4'hf) ? sp : wreg[rd_sel_a];
  assign rd_data_b = (rd_sel_b == 4'hf) ? sp : wreg[rd_sel_b];

  ////////////////////////////////////////////////////////////////////////////
  // shadows only move on events
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        wshadow[i] <= 16'h0000;
      end
      sr_shadow <= 16'h0000;
      shadow_valid <= 1'b0;
    end else if (shadow_push) begin
      for (int i = 0; i < 4; i++) begin
        wshadow[i] <= wreg[i];
      end
      sr_shadow <= status_reg & cprm_pkg::SR_SHADOW_MASK;
      shadow_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word
  always_ff @(posedge clk) begin
    if (reset) begin
      status_reg <= cprm_pkg::SR_RESET;
    end else begin
      if (reg_write && reg_addr == cprm_pkg::OFS_STATUS) begin
        if (reg_wbyte[0]) begin
          status_reg[7:0] <= (reg_wdata[7:0] & ~cprm_pkg::SR_HW_MASK[7:0]) |
                             (status_reg[7:0] & cprm_pkg::SR_HW_MASK[7:0]);
        end
        if (reg_wbyte[1]) begin
          status_reg[15:8] <= (reg_wdata[15:8] & ~cprm_pkg::SR_HW_MASK[15:8]) |
                              (status_reg[15:8] & cprm_pkg::SR_HW_MASK[15:8]);
        end
      end
      if (flag_en) begin
        status_reg <= (status_reg & ~flag_mask) | (flag_data & flag_mask);
      end
      if (shadow_pop && shadow_valid) begin
        status_reg <= (status_reg & ~cprm_pkg::SR_SHADOW_MASK) | sr_shadow;
      end
      if (repeat_start) begin
        status_reg[cprm_pkg::SR_RA] <= 1'b1;
      end else if (repeat_done) begin
        status_reg[cprm_pkg::SR_RA] <= 1'b0;
      end
      if (loop_enter) begin
        status_reg[cprm_pkg::SR_DA] <= 1'b1;
      end else if (loop_exit) begin
        status_reg[cprm_pkg::SR_DA] <= 1'b0;
      end
      if (exc_ack && exc_state == cprm_pkg::CPRM_EXC_IDLE && best_pri < 4'h8) begin
        status_reg[cprm_pkg::SR_IPL_LO +: 3] <= best_pri[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop registers and shadows
  always_ff @(posedge clk) begin
    if (reset) begin
      loop_counter <= 14'h0000;
      loop_start_address <= 23'h000000;
      loop_end_address <= 23'h000000;
      lc_shadow <= 14'h0000;
      ls_shadow <= 23'h000000;
      le_shadow <= 23'h000000;
      repeat_counter <= 14'h0000;
    end else begin
      if (loop_enter) begin
        lc_shadow <= loop_counter;
        ls_shadow <= loop_start_address;
        le_shadow <= loop_end_address;
        loop_counter <= loop_count_in;
        loop_start_address <= {loop_start_in[22:1], 1'b0};
        loop_end_address <= {loop_end_in[22:1], 1'b0};
      end else if (loop_exit) begin
        loop_counter <= lc_shadow;
        loop_start_address <= ls_shadow;
        loop_end_address <= le_shadow;
      end else if (reg_write && reg_addr == cprm_pkg::OFS_LPCNT) begin
        loop_counter <= reg_wdata[13:0];
      end
      if (repeat_start) begin
        repeat_counter <= repeat_count_in;
      end else if (reg_write && reg_addr == cprm_pkg::OFS_RPTCNT) begin
        repeat_counter <= reg_wdata[13:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pc always even
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_reg <= cprm_pkg::PC_RESET;
    end else if (pc_load) begin
      pc_reg <= {pc_target[22:1], 1'b0};
    end else if (pc_advance) begin
      pc_reg <= pc_reg + 23'h000002;
    end
  end
  assign pc_value = pc_reg;
  assign fetch_addr = pc_special ? pc_reg : {1'b0, pc_reg[21:0]};

  always_ff @(posedge clk) begin
    if (reset) begin
      instr_reg <= 24'h000000;
    end else if (pc_advance || pc_load) begin
      instr_reg <= fetch_word;
    end
  end
  assign instr_word = instr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // x/y generators
  assign x_en = 1'b1;
  assign y_en = dual_op;
  assign psv_access = (x_ea >= cprm_pkg::PSV_BASE);
  assign psv_addr = {program_visibility_page, x_ea[14:0]};
  always_ff @(posedge clk) begin
    if (reset) begin
      psv_wait_reg <= 1'b0;
    end else begin
      psv_wait_reg <= psv_access && !psv_wait_reg;
    end
  end
  // extra cycle: stall until second cycle of the access
  assign psv_wait = psv_access && !psv_wait_reg;
  assign tbl_addr = {table_page_reg[6:0], tbl_offset};

  always_ff @(posedge clk) begin
    if (reset) begin
      table_page_reg <= 8'h00;
      program_visibility_page <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == cprm_pkg::OFS_TBLPG && reg_wbyte[0]) begin
        table_page_reg <= reg_wdata[7:0];
      end
      if (reg_addr == cprm_pkg::OFS_PSVPG && reg_wbyte[0]) begin
        program_visibility_page <= reg_wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector selection
  // priority: traps 8..15, irq by level then natural order
  always_comb begin
    best_pri = 4'h0;
    vec_next = 6'h00;
    pend_next = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_req[i] && irq_pri[3*i +: 3] >= cprm_pkg::IRQ_PRI_MIN &&
          {1'b0, irq_pri[3*i +: 3]} >= best_pri &&
          irq_pri[3*i +: 3] > status_reg[cprm_pkg::SR_IPL_LO +: 3]) begin
        best_pri = {1'b0, irq_pri[3*i +: 3]};
        vec_next = 6'(NUM_TRAP + i);
        pend_next = 1'b1;
      end
    end
    for (int t = 0; t < NUM_TRAP; t++) begin
      if (trap_req[t] && (cprm_pkg::TRAP_PRI_BASE + 4'(t)) >= best_pri) begin
        best_pri = cprm_pkg::TRAP_PRI_BASE + 4'(t);
        vec_next = 6'(t);
        pend_next = 1'b1;
      end
    end
  end

  // exception entry pushes pc then status
  always_ff @(posedge clk) begin
    if (reset) begin
      exc_state <= cprm_pkg::CPRM_EXC_IDLE;
      exc_pending <= 1'b0;
      exc_vector <= 6'h00;
    end else begin
      exc_pending <= pend_next;
      exc_vector <= vec_next;
      case (exc_state)
        cprm_pkg::CPRM_EXC_IDLE: begin
          if (exc_ack && exc_pending) begin
            exc_state <= cprm_pkg::CPRM_EXC_PUSH_PC;
          end
        end
        cprm_pkg::CPRM_EXC_PUSH_PC: exc_state <= cprm_pkg::CPRM_EXC_PUSH_SR;
        cprm_pkg::CPRM_EXC_PUSH_SR: exc_state <= cprm_pkg::CPRM_EXC_IDLE;
        default: exc_state <= cprm_pkg::CPRM_EXC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // barrel shift, negative is right
  always_comb begin
    shift_out = shift_in;
    if (shift_amt < 0 && shift_amt >= -6'sd15) begin
      shift_out = 40'($signed(shift_in) >>> (-shift_amt));
    end else if (shift_amt > 0 && shift_amt <= 6'sd16) begin
      shift_out = shift_in << shift_amt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, data one cycle later; shadows never visible
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      if (map_hit) begin
        reg_rdata <= (map_idx == 4'hf) ? sp : wreg[map_idx];
      end else begin
        case (reg_addr)
          cprm_pkg::OFS_PCL: reg_rdata <= pc_reg[15:0];
          cprm_pkg::OFS_PCH: reg_rdata <= {9'h000, pc_reg[22:16]};
          cprm_pkg::OFS_TBLPG: reg_rdata <= {8'h00, table_page_reg};
          cprm_pkg::OFS_PSVPG: reg_rdata <= {8'h00, program_visibility_page};
          cprm_pkg::OFS_RPTCNT: reg_rdata <= {2'h0, repeat_counter};
          cprm_pkg::OFS_LPCNT: reg_rdata <= {2'h0, loop_counter};
          cprm_pkg::OFS_LPSTL: reg_rdata <= loop_start_address[15:0];
          cprm_pkg::OFS_LPSTH: reg_rdata <= {9'h000, loop_start_address[22:16]};
          cprm_pkg::OFS_LPENL: reg_rdata <= loop_end_address[15:0];
          cprm_pkg::OFS_LPENH: reg_rdata <= {9'h000, loop_end_address[22:16]};
          cprm_pkg::OFS_STATUS: reg_rdata <= status_reg;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : cprm_core_regs

// ==== tb/cprm_core_regs_asserts.sv ====
// port assertions for the core register model
// assumes it is bound into cprm_core_regs
`timescale 1ns/100ps
module cprm_core_regs_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0] rd_sel_a,
  input wire logic [15:0] rd_data_a,
  input wire logic pc_special,
  input wire logic [22:0] pc_value,
  input wire logic [22:0] fetch_addr,
  input wire logic call_push,
  input wire logic [15:0] stack_addr,
  input wire logic stack_we,
  input wire logic [15:0] x_ea,
  input wire logic dual_op,
  input wire logic x_en,
  input wire logic y_en,
  input wire logic psv_access,
  input wire logic [22:0] psv_addr,
  input wire logic [15:0] tbl_offset,
  input wire logic [22:0] tbl_addr,
  input wire logic exc_ack,
  input wire logic exc_pending,
  input wire logic [39:0] shift_in,
  input wire logic signed [5:0] shift_amt,
  input wire logic [39:0] shift_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  a_sp_low_clear: assert property (rd_sel_a == 4'hf |-> !rd_data_a[0])
    else $error("stack pointer bit 0 set");
  a_pc_even: assert property (!pc_value[0])
    else $error("pc bit 0 set");
  a_top_bit_masked: assert property (!pc_special |-> !fetch_addr[22])
    else $error("fetch top bit leaked");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_agu_select: assert property (x_en && y_en == dual_op)
    else $error("address generator select wrong");
  a_psv_window: assert property (psv_access == x_ea[15]
    && (!psv_access || psv_addr[14:0] == x_ea[14:0]))
    else $error("visibility window wrong");
  a_table_reach: assert property (tbl_addr[15:0] == tbl_offset)
    else $error("table offset lost");
  a_call_stacks: assert property (call_push |-> stack_we)
    else $error("call without stack write");
  a_exc_two_push: assert property (exc_pending && exc_ack |=> stack_we
    ##1 stack_we && stack_addr == $past(stack_addr) + 16'h0002 ##1 !stack_we)
    else $error("exception stacking wrong");
  a_shift_left: assert property (shift_amt > 0 && shift_amt < 17
    |-> shift_out == shift_in << shift_amt)
    else $error("left shift wrong");
endmodule : cprm_core_regs_asserts

bind cprm_core_regs cprm_core_regs_asserts cprm_core_regs_asserts_i (.*);

// ==== tb/cprm_mem_model.sv ====
// program and data memory beside the register model
// assumes word-aligned stack traffic and combinational reads
`timescale 1ns/100ps
module cprm_mem_model (
  // clock
  input wire logic clk,
  // program side
  input wire logic [22:0] fetch_addr,
  output logic [23:0] fetch_word,
  // stack side
  input wire logic [15:0] stack_addr,
  input wire logic [15:0] stack_wdata,
  input wire logic stack_we,
  output logic [15:0] stack_rdata
);
  logic [15:0] data_mem [32768];
  ////////////////////////////////////////////////////////////////////////////////
  // full width words
  // top bit set so a truncated fetch path shows up
  assign fetch_word = {1'b1, fetch_addr};
  // stack word storage
  // filled with a pattern so a stale read never looks like zero
  initial begin
    for (int i = 0; i < 32768; i++) data_mem[i] = ~16'(i);
  end
  assign stack_rdata = data_mem[stack_addr[15:1]];
  always @(posedge clk) begin
    if (stack_we) data_mem[stack_addr[15:1]] <= stack_wdata;
  end
endmodule : cprm_mem_model

// ==== tb/test_cpu_programmer_register_model.sv ====
// testbench for the core register model
// assumes the memory model as far side and the bound checker
`timescale 1ns/100ps
module test_cpu_programmer_register_model;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] d;
    logic [1:0] l;
    logic [15:0] e;
  } cprm_row_t;
  logic clk, reset, reg_write, reg_read, wr_en, wr_byte, flag_en, pc_advance, pc_load;
  logic pc_special, call_push, ret_pop, stack_we, frame_link, frame_unlink, shadow_push;
  logic shadow_pop, loop_enter, loop_exit, repeat_start, repeat_done, dual_op, x_en, y_en;
  logic psv_access, psv_wait, exc_ack, exc_pending;
  logic [1:0] reg_wbyte;
  logic [3:0] wr_sel, rd_sel_a, rd_sel_b;
  logic [5:0] exc_vector;
  logic [7:0] trap_req;
  logic [13:0] frame_size, loop_count_in, repeat_count_in;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, wr_data, rd_data_a, rd_data_b, flag_data;
  logic [15:0] flag_mask, stack_rdata, stack_addr, stack_wdata, x_ea, y_ea, tbl_offset;
  logic [22:0] pc_target, pc_value, fetch_addr, loop_start_in, loop_end_in, psv_addr, tbl_addr;
  logic [23:0] fetch_word, instr_word;
  logic [39:0] shift_in, shift_out;
  logic signed [5:0] shift_amt;
  logic [53:0] irq_req;
  logic [161:0] irq_pri;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  cprm_row_t rows [9] = '{
    '{16'h0000, 16'h1234, 2'h3, 16'h1234},
    '{16'h0002, 16'habcd, 2'h1, 16'h00cd},
    '{16'h0002, 16'h5500, 2'h2, 16'h55cd},
    '{16'h001e, 16'h1235, 2'h3, 16'h1234},
    '{16'h001c, 16'h0900, 2'h3, 16'h0900},
    '{16'h0032, 16'h0012, 2'h3, 16'h0012},
    '{16'h0034, 16'h0003, 2'h3, 16'h0003},
    '{16'h0042, 16'h0210, 2'h3, 16'h0000},
    '{16'h0100, 16'hffff, 2'h3, 16'h0000}};
  cprm_core_regs cprm_core_regs_i (.*);
  cprm_mem_model cprm_mem_model_i (.*);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input string n, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // bus cycles start and end just after a rising edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] l);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wbyte <= l;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input string n, input logic [15:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(n, e, reg_rdata);
    @(posedge clk);
  endtask : rd
  task automatic exc(input logic [7:0] t, input logic [53:0] q, input logic [161:0] p,
      input logic v_ok, input logic [5:0] v);
    trap_req <= t;
    irq_req <= q;
    irq_pri <= p;
    repeat (2) @(posedge clk);
    #1 check("pending", v_ok, exc_pending);
    if (v_ok) check("vector", v, exc_vector);
    @(posedge clk);
  endtask : exc
  task automatic shf(input logic signed [5:0] a, input logic [39:0] e);
    shift_amt <= a;
    #1 check("shift", e, shift_out);
    @(posedge clk);
  endtask : shf
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reg_write, reg_read, wr_en, wr_byte, flag_en, pc_advance, pc_load, pc_special} = '0;
    {call_push, ret_pop, frame_link, frame_unlink, shadow_push, shadow_pop} = '0;
    {loop_enter, loop_exit, repeat_start, repeat_done, dual_op, exc_ack, reg_wbyte} = '0;
    {reg_addr, reg_wdata, wr_sel, wr_data, rd_sel_a, rd_sel_b, flag_data, flag_mask} = '0;
    {pc_target, frame_size, loop_start_in, loop_end_in, loop_count_in} = '0;
    {repeat_count_in, x_ea, y_ea, tbl_offset, irq_req, irq_pri, trap_req} = '0;
    {shift_in, shift_amt} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd("sp", 16'h001e, 16'h0800);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].l);
      rd("row", rows[i].a, rows[i].e);
    end
    wr_sel <= 4'h2;
    wr_data <= 16'hbeef;
    wr_byte <= 1'b1;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
    rd("byte op", 16'h0004, 16'h00ef);
    rd_sel_a <= 4'hf;
    call_push <= 1'b1;
    #1 check("sp port", 16'h1234, rd_data_a);
    check("push addr", 16'h1234, stack_addr);
    @(posedge clk);
    call_push <= 1'b0;
    @(posedge clk);
    rd("sp call", 16'h001e, 16'h1236);
    ret_pop <= 1'b1;
    @(posedge clk);
    ret_pop <= 1'b0;
    frame_size <= 14'h0002;
    frame_link <= 1'b1;
    @(posedge clk);
    frame_link <= 1'b0;
    frame_unlink <= 1'b1;
    @(posedge clk);
    frame_unlink <= 1'b0;
    @(posedge clk);
    rd("fp", 16'h001c, 16'h0900);
    rd("sp", 16'h001e, 16'h1234);
    flag_data <= 16'h010f;
    flag_mask <= 16'h010f;
    flag_en <= 1'b1;
    @(posedge clk);
    flag_en <= 1'b0;
    shadow_push <= 1'b1;
    @(posedge clk);
    shadow_push <= 1'b0;
    wr_sel <= 4'h0;
    wr_data <= 16'h2222;
    wr_byte <= 1'b0;
    wr_en <= 1'b1;
    flag_data <= 16'h0000;
    flag_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    flag_en <= 1'b0;
    shadow_pop <= 1'b1;
    @(posedge clk);
    shadow_pop <= 1'b0;
    @(posedge clk);
    rd("w0 pop", 16'h0000, 16'h1234);
    rd("flags pop", 16'h0042, 16'h010f);
    loop_start_in <= 23'h000100;
    loop_end_in <= 23'h000140;
    loop_count_in <= 14'h0005;
    repeat_count_in <= 14'h0012;
    loop_enter <= 1'b1;
    repeat_start <= 1'b1;
    @(posedge clk);
    loop_enter <= 1'b0;
    repeat_start <= 1'b0;
    @(posedge clk);
    rd("loop cnt", 16'h0038, 16'h0005);
    rd("rep cnt", 16'h0036, 16'h0012);
    rd("status", 16'h0042, 16'h031f);
    loop_exit <= 1'b1;
    repeat_done <= 1'b1;
    @(posedge clk);
    loop_exit <= 1'b0;
    repeat_done <= 1'b0;
    @(posedge clk);
    rd("loop cnt", 16'h0038, 16'h0000);
    rd("status", 16'h0042, 16'h010f);
    pc_target <= 23'h400003;
    pc_load <= 1'b1;
    @(posedge clk);
    pc_load <= 1'b0;
    pc_advance <= 1'b1;
    #1 check("pc", 23'h400002, pc_value);
    @(posedge clk);
    pc_advance <= 1'b0;
    pc_special <= 1'b1;
    #1 check("pc", 23'h400004, pc_value);
    check("fetch top", 1'b1, fetch_addr[22]);
    check("instr", 24'h800002, instr_word);
    @(posedge clk);
    pc_special <= 1'b0;
    x_ea <= 16'h8010;
    dual_op <= 1'b1;
    tbl_offset <= 16'hc0de;
    #1 check("psv", {1'b1, 8'h03, 15'h0010}, {psv_access, psv_addr});
    check("psv wait", 1'b1, psv_wait);
    check("y gen", 1'b1, y_en);
    check("tbl", {7'h12, 16'hc0de}, tbl_addr);
    @(posedge clk);
    x_ea <= 16'h7ffe;
    dual_op <= 1'b0;
    shift_in <= 40'h8000000001;
    #1 check("psv off", 2'b00, {psv_access, y_en});
    @(posedge clk);
    shf(6'sd16, 40'h0000010000);
    shf(-6'sd15, 40'hffff000000);
    shf(6'sd17, 40'h8000000001);
    shf(-6'sd16, 40'h8000000001);
    exc(8'h08, '0, '0, 1'b1, 6'd3);
    exc('0, 54'h220, (162'h3 << 15) | (162'h3 << 27), 1'b1, 6'd13);
    exc('0, 54'h220, (162'h3 << 15) | (162'h7 << 27), 1'b1, 6'd17);
    exc('0, 54'h020, '0, 1'b0, 6'd0);
    exc(8'h01, 54'h200, 162'h7 << 27, 1'b1, 6'd0);
    exc_ack <= 1'b1;
    trap_req <= '0;
    irq_req <= '0;
    @(posedge clk);
    exc_ack <= 1'b0;
    repeat (3) @(posedge clk);
    rd("sp exc", 16'h001e, 16'h1238);
    check("pc low", 16'h0004, cprm_mem_model_i.data_mem[15'h091a]);
    check("sr word", 16'h800f, cprm_mem_model_i.data_mem[15'h091b]);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd("sp", 16'h001e, 16'h0800);
    conclude();
  end
endmodule : test_cpu_programmer_register_model
